// ===== shared/ipa_pkg.sv
// Purpose: constants shared by the register-bank device end and its host
// Assumes: 8-bit registers behind a 10-bit register address
// Notes: host-side APB map offsets live here too
package ipa_pkg;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;
	// ------------------------------------------------------------------
	// device register map
	// ------------------------------------------------------------------
	localparam logic [9:0] ADDR_STARTUP = 10'h270;
	localparam logic [9:0] ADDR_PROF_B = 10'h29A;
	localparam logic [9:0] ADDR_PROF_C = 10'h29B;
	localparam logic [9:0] ADDR_PROF_D = 10'h29C;
	localparam logic [9:0] ADDR_ALARM = 10'h2C0;
	localparam logic [9:0] ADDR_FLAGS = 10'h2C1;
	localparam logic [9:0] ADDR_MASKS = 10'h2C2;
	localparam logic [7:0] PROF_B_LOW = 8'h06;
	localparam logic [7:0] PROF_B_HIGH = 8'h0F;
	localparam logic [7:0] PROF_C_LOW = 8'h00;
	localparam logic [7:0] PROF_C_HIGH = 8'h04;
	localparam logic [7:0] PROF_D_LOW = 8'h14;
	localparam logic [7:0] PROF_D_HIGH = 8'h1B;
	localparam logic [5:0] ALM_RESET = 6'h3F;
	localparam int ALM_W = 6;
	localparam int INIT_CYCLES = 16;
	// ------------------------------------------------------------------
	// host APB map (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [7:0] APB_CMD = 8'h00;
	localparam logic [7:0] APB_WDATA = 8'h04;
	localparam logic [7:0] APB_RDATA = 8'h08;
	localparam logic [7:0] APB_STATUS = 8'h0C;
	localparam logic [7:0] APB_IRQ_STAT = 8'h10;
	localparam logic [7:0] APB_IRQ_CLR = 8'h14;
	localparam logic [7:0] APB_IRQ_EN = 8'h18;
	localparam logic [7:0] APB_PROFILE = 8'h1C;
	// cmd word: [9:0] address, [16] write, [17] go
	localparam int CMD_WR_BIT = 16;
	localparam int CMD_GO_BIT = 17;
	localparam int CMD_PROF_BIT = 18;
	localparam int CMD_RST_BIT = 19;
endpackage

// ===== shared/ipa_if.sv
// Purpose: register access channel between host and device end
// Assumes: single clock, request held until ack
// Notes: one access outstanding at a time
`timescale 1ns/100ps
interface ipa_if;
	logic req;
	logic wr;
	logic [9:0] addr;
	logic [7:0] wdata;
	logic soft_rst;
	logic ack;
	logic [7:0] rdata;
	logic status_pin;
	modport device (input req, wr, addr, wdata, soft_rst,
		output ack, rdata, status_pin);
	modport host (output req, wr, addr, wdata, soft_rst,
		input ack, rdata, status_pin);
endinterface

// ===== core/ipa_alarm_sum.sv
// Purpose: sticky alarm flags, masks and summary bit
// Assumes: flag events are synchronous to sys_clk_in
// Notes: write-one-to-clear, set wins over clear
`timescale 1ns/100ps
module ipa_alarm_sum
	import ipa_pkg::*;
#(
	parameter int W = ALM_W
) (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic soft_rst_in,
	// events and software access
	input wire logic [W-1:0] alarm_event_in,
	input wire logic [W-1:0] clear_in,
	input wire logic mask_we_in,
	input wire logic [W-1:0] mask_in,
	// state
	output logic [W-1:0] flags_out,
	output logic [W-1:0] masks_out,
	output logic summary_out
);
	logic [W-1:0] flags_q;
	logic [W-1:0] masks_q;
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_flag
			always_ff @(posedge sys_clk_in) begin
				if (!rst_n_in || soft_rst_in) begin
					flags_q[i] <= ALM_RESET[i];
				end else if (alarm_event_in[i]) begin
					flags_q[i] <= 1'b1;
				end else if (clear_in[i]) begin
					flags_q[i] <= 1'b0;
				end
			end
		end
	endgenerate
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in || soft_rst_in) begin
			masks_q <= ALM_RESET[W-1:0];
		end else if (mask_we_in) begin
			masks_q <= mask_in;
		end
	end
	assign flags_out = flags_q;
	assign masks_out = masks_q;
	// combinational so summary follows flags/masks in the same cycle
	assign summary_out = |(flags_q & ~masks_q);
endmodule

// ===== core/ipa_device.sv
// Purpose: device end: init flag, power-profile regs, alarm summary
// Assumes: host keeps one request high until ack
// Notes: ack one cycle after req; reserved profile values refused
`timescale 1ns/100ps

module ipa_device
	import ipa_pkg::*;
#(
	parameter int INIT_LEN = INIT_CYCLES
) (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// link
	ipa_if.device link,
	// user side
	input wire logic [ALM_W-1:0] alarm_event_in,
	input wire logic pin_sel_alarm_in,
	input wire logic cal_status_in,
	output logic init_done_out,
	output logic [7:0] profile_b_out,
	output logic [7:0] profile_c_out,
	output logic [7:0] profile_d_out
);
	logic [7:0] init_cnt_q;
	logic init_done_q;
	logic [7:0] prof_b_q;
	logic [7:0] prof_c_q;
	logic [7:0] prof_d_q;
	logic ack_q;
	logic [7:0] rdata_q;
	logic [ALM_W-1:0] flags;
	logic [ALM_W-1:0] masks;
	logic summary;
	logic take;
	logic wr_go;
	logic [ALM_W-1:0] clr;

	assign take = link.req && !ack_q;
	assign wr_go = take && link.wr;
	assign clr = (wr_go && link.addr == ADDR_FLAGS) ?
		link.wdata[ALM_W-1:0] : '0;

	// ------------------------------------------------------------------
	// startup sequence
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in || link.soft_rst) begin
			init_cnt_q <= 8'h00;
			init_done_q <= 1'b0;
		end else if (init_cnt_q == 8'(INIT_LEN)) begin
			init_done_q <= 1'b1;
		end else begin
			init_cnt_q <= init_cnt_q + 8'h01;
		end
	end

	// ------------------------------------------------------------------
	// power profile registers
	// ------------------------------------------------------------------
	// reserved codes are dropped so the profile never leaves a legal value
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in || link.soft_rst) begin
			prof_b_q <= PROF_B_HIGH;
			prof_c_q <= PROF_C_HIGH;
			prof_d_q <= PROF_D_HIGH;
		end else if (wr_go) begin
			if (link.addr == ADDR_PROF_B && (link.wdata == PROF_B_LOW ||
				link.wdata == PROF_B_HIGH)) begin
				prof_b_q <= link.wdata;
			end
			if (link.addr == ADDR_PROF_C && (link.wdata == PROF_C_LOW ||
				link.wdata == PROF_C_HIGH)) begin
				prof_c_q <= link.wdata;
			end
			if (link.addr == ADDR_PROF_D && (link.wdata == PROF_D_LOW ||
				link.wdata == PROF_D_HIGH)) begin
				prof_d_q <= link.wdata;
			end
		end
	end

	// ------------------------------------------------------------------
	// alarms
	// ------------------------------------------------------------------
	ipa_alarm_sum #(.W(ALM_W)) u_alarm (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.soft_rst_in(link.soft_rst),
		.alarm_event_in(alarm_event_in),
		.clear_in(clr),
		.mask_we_in(wr_go && link.addr == ADDR_MASKS),
		.mask_in(link.wdata[ALM_W-1:0]),
		.flags_out(flags),
		.masks_out(masks),
		.summary_out(summary)
	);
	assign link.status_pin = pin_sel_alarm_in ? summary :
		cal_status_in;

	// ------------------------------------------------------------------
	// read and ack
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			ack_q <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			ack_q <= take;
			if (take && !link.wr) begin
				unique case (link.addr)
					ADDR_STARTUP: rdata_q <= {7'h00, init_done_q};
					ADDR_PROF_B: rdata_q <= prof_b_q;
					ADDR_PROF_C: rdata_q <= prof_c_q;
					ADDR_PROF_D: rdata_q <= prof_d_q;
					ADDR_ALARM: rdata_q <= {7'h00, summary};
					ADDR_FLAGS: rdata_q <= {2'b00, flags};
					ADDR_MASKS: rdata_q <= {2'b00, masks};
					default: rdata_q <= 8'h00;
				endcase
			end
		end
	end
	assign link.ack = ack_q;
	assign link.rdata = rdata_q;
	assign init_done_out = init_done_q;
	assign profile_b_out = prof_b_q;
	assign profile_c_out = prof_c_q;
	assign profile_d_out = prof_d_q;
endmodule

// ===== core/ipa_host.sv
// Purpose: host end: APB-commanded register accesses to the device
// Assumes: APB master keeps request until pready
// Notes: accesses blocked until init flag seen, except soft reset
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
module ipa_host
	import ipa_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// apb slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	output logic irq_out,
	// link
	ipa_if.host link
);
	typedef enum logic [3:0] {
		ST_POLL = 4'b0001, ST_IDLE = 4'b0010,
		ST_ACC = 4'b0100, ST_PROF = 4'b1000
	} ipa_st_t;
	ipa_st_t st_q;
	logic ready_q;
	logic [9:0] addr_q;
	logic wr_q;
	logic [7:0] wdata_q;
	logic [7:0] rdata_q;
	logic [1:0] prof_idx_q;
	logic low_q;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_en_q;
	logic rst_q;
	logic apb_wr;
	logic go;
	logic [1:0] ev;

	assign apb_wr = psel_in && penable_in && pwrite_in;
	assign go = apb_wr && paddr_in == APB_CMD && pwdata_in[CMD_GO_BIT];
	// ev[0] access done, ev[1] device ready seen
	assign ev = {st_q == ST_POLL && link.ack && link.rdata[0],
		link.ack && st_q != ST_POLL};

	// ------------------------------------------------------------------
	// access sequencer
	// ------------------------------------------------------------------
	// profile walk writes b, c, d back to back; caller has already
	// dropped calibration and link enable and calibrates afterwards
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			st_q <= ST_POLL;
			ready_q <= 1'b0;
			addr_q <= ADDR_STARTUP;
			wr_q <= 1'b0;
			wdata_q <= 8'h00;
			rdata_q <= 8'h00;
			prof_idx_q <= 2'd0;
			low_q <= 1'b0;
		end else begin
			unique case (st_q)
				ST_POLL: begin
					if (link.ack) begin
						ready_q <= link.rdata[0];
						st_q <= link.rdata[0] ? ST_IDLE : ST_POLL;
					end
				end
				ST_IDLE: begin
					if (go && pwdata_in[CMD_PROF_BIT]) begin
						low_q <= pwdata_in[0];
						prof_idx_q <= 2'd0;
						addr_q <= ADDR_PROF_B;
						wr_q <= 1'b1;
						wdata_q <= pwdata_in[0] ? PROF_B_LOW : PROF_B_HIGH;
						st_q <= ST_PROF;
					end else if (go) begin
						addr_q <= pwdata_in[9:0];
						wr_q <= pwdata_in[CMD_WR_BIT];
						st_q <= ST_ACC;
					end
				end
				ST_ACC: begin
					if (link.ack) begin
						rdata_q <= link.rdata;
						st_q <= ST_IDLE;
					end
				end
				ST_PROF: begin
					if (link.ack) begin
						prof_idx_q <= prof_idx_q + 2'd1;
						addr_q <= (prof_idx_q == 2'd0) ? ADDR_PROF_C : ADDR_PROF_D;
						wdata_q <= (prof_idx_q == 2'd0) ?
							(low_q ? PROF_C_LOW : PROF_C_HIGH) :
							(low_q ? PROF_D_LOW : PROF_D_HIGH);
						if (prof_idx_q == 2'd2) begin
							st_q <= ST_IDLE;
						end
					end
				end
				default: st_q <= ST_POLL;
			endcase
			if (apb_wr && paddr_in == APB_WDATA && st_q != ST_PROF) begin
				wdata_q <= pwdata_in[7:0];
			end
			if (rst_q) begin
				st_q <= ST_POLL;
				ready_q <= 1'b0;
				addr_q <= ADDR_STARTUP;
				wr_q <= 1'b0;
			end
		end
	end

	// soft reset pulse, the one access allowed before ready
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			rst_q <= 1'b0;
		end else begin
			rst_q <= go && pwdata_in[CMD_RST_BIT];
		end
	end

	// ------------------------------------------------------------------
	// interrupts
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			irq_stat_q <= 2'b00;
			irq_en_q <= 2'b00;
		end else begin
			irq_stat_q <= ev | (irq_stat_q & ~((apb_wr &&
				paddr_in == APB_IRQ_CLR) ? pwdata_in[1:0] : 2'b00));
			if (apb_wr && paddr_in == APB_IRQ_EN) begin
				irq_en_q <= pwdata_in[1:0];
			end
		end
	end
	assign irq_out = |(irq_stat_q & irq_en_q);

	// ------------------------------------------------------------------
	// apb read side
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			prdata_out <= 32'h0000_0000;
		end else if (psel_in && !penable_in) begin
			unique case (paddr_in)
				APB_CMD: prdata_out <= {22'h0, addr_q};
				APB_WDATA: prdata_out <= {24'h0, wdata_q};
				APB_RDATA: prdata_out <= {24'h0, rdata_q};
				APB_STATUS: prdata_out <= {27'h0, link.status_pin, st_q == ST_IDLE,
					ready_q, 2'b00};
				APB_IRQ_STAT: prdata_out <= {30'h0, irq_stat_q};
				APB_IRQ_EN: prdata_out <= {30'h0, irq_en_q};
				APB_PROFILE: prdata_out <= {31'h0, low_q};
				default: prdata_out <= 32'h0000_0000;
			endcase
		end
	end
	assign pready_out = 1'b1;
	assign pslverr_out = 1'b0;
	assign link.req = (st_q != ST_IDLE) && !rst_q;
	assign link.wr = wr_q && st_q != ST_POLL;
	assign link.addr = addr_q;
	assign link.wdata = wdata_q;
	assign link.soft_rst = rst_q;
endmodule

// ===== test/ipa_properties.sv
// Purpose: link protocol and register content checks
// Assumes: both link ends are design modules
// Notes: sees only the link signals
`timescale 1ns/100ps
module ipa_properties
	import ipa_pkg::*;
#(
	parameter int INIT_LEN = INIT_CYCLES
) (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// link signals
	input wire logic req,
	input wire logic wr,
	input wire logic [9:0] addr,
	input wire logic [7:0] wdata,
	input wire logic soft_rst,
	input wire logic ack,
	input wire logic [7:0] rdata,
	input wire logic status_pin
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	logic seen_q;
	int cnt_q;
	// ----------------------------------------
	// helper state
	// ----------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in)
			cnt_q <= 0;
		else if (cnt_q < 1000)
			cnt_q <= cnt_q + 1;
	end
	// init flag seen by the host on the link
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in)
			seen_q <= 1'b0;
		else if (ack && !wr && addr == ADDR_STARTUP && rdata[0])
			seen_q <= 1'b1;
	end
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_ack_after_req: assert property (req && !ack |=> ack)
		else $error("request not acked next cycle");
	a_ack_one_cycle: assert property (ack |=> !ack)
		else $error("ack longer than one cycle");
	a_req_held: assert property (req && !ack |=> req && $stable(addr)
		&& $stable(wr) && $stable(wdata))
		else $error("request changed before ack");
	a_rdata_stands: assert property (ack && !wr |=> $stable(rdata))
		else $error("read data changed right after ack");
	a_init_gate: assert property (
		req && addr != ADDR_STARTUP |-> seen_q)
		else $error("access before init flag seen");
	a_init_late: assert property (
		ack && !wr && addr == ADDR_STARTUP && rdata[0] |-> cnt_q > INIT_LEN)
		else $error("init flag set too early");
	a_resv_zero: assert property (
		ack && !wr && (addr == ADDR_STARTUP || addr == ADDR_ALARM)
		|-> rdata[7:1] == 7'h00)
		else $error("reserved bits not zero");
	a_prof_legal: assert property (
		ack && !wr && addr == ADDR_PROF_B |-> rdata inside {8'h06, 8'h0F})
		else $error("profile b holds reserved code");
endmodule

// ===== test/test_init_power_alarm_regs.sv
// Purpose: end-to-end bench, APB to host to device
// Assumes: zero-wait APB, short init count
// Notes: device accesses completed via access-done irq
`timescale 1ns/100ps
module test_init_power_alarm_regs
	import ipa_pkg::*;
();
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
	logic pin_sel, cal_st, init_done;
	logic [7:0] paddr, prof_b, prof_c, prof_d, r;
	logic [31:0] pwdata, prdata, t;
	logic [5:0] alm_ev;
	logic [9:0] ra [6];
	logic [7:0] rv [6];
	logic [7:0] lo [3];
	int bad_count, comparisons, i, n;
	ipa_if ipa_if_i();
	ipa_device #(.INIT_LEN(4)) ipa_device_i(.sys_clk_in(clk),
		.rst_n_in(rst_n), .link(ipa_if_i), .alarm_event_in(alm_ev),
		.pin_sel_alarm_in(pin_sel), .cal_status_in(cal_st),
		.init_done_out(init_done), .profile_b_out(prof_b),
		.profile_c_out(prof_c), .profile_d_out(prof_d));
	ipa_host ipa_host_i(.sys_clk_in(clk), .rst_n_in(rst_n),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .irq_out(irq),
		.link(ipa_if_i));
	ipa_properties #(.INIT_LEN(4)) ipa_properties_i(.sys_clk_in(clk),
		.rst_n_in(rst_n), .req(ipa_if_i.req), .wr(ipa_if_i.wr),
		.addr(ipa_if_i.addr), .wdata(ipa_if_i.wdata),
		.soft_rst(ipa_if_i.soft_rst), .ack(ipa_if_i.ack),
		.rdata(ipa_if_i.rdata), .status_pin(ipa_if_i.status_pin));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task close_out;
		$display("checks %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// only the watchdog ends a wait for the slave
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		t = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// one device access; completion seen on the irq line
	task dev(input logic w, input logic [9:0] a, input logic [7:0] d);
		logic [31:0] c;
		int k;
		c = 32'h0;
		c[9:0] = a;
		c[CMD_WR_BIT] = w;
		c[CMD_GO_BIT] = 1'b1;
		k = 0;
		apb(1'b1, APB_WDATA, {24'h0, d});
		apb(1'b1, APB_CMD, c);
		while (irq !== 1'b1 && k < 100) begin
			@(posedge clk);
			k++;
		end
		chk(irq, 1'b1);
		apb(1'b1, APB_IRQ_CLR, 32'h1);
		apb(1'b0, APB_RDATA, 32'h0);
		r = t[7:0];
	endtask
	// ----------------------------------------
	// clock, watchdog, tests
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		close_out;
	end
	initial begin
		{rst_n, psel, penable, pwrite, cal_st} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		alm_ev = 6'h00;
		pin_sel = 1'b1;
		bad_count = 0;
		comparisons = 0;
		ra = '{ADDR_PROF_B, ADDR_PROF_C, ADDR_PROF_D, ADDR_ALARM,
			ADDR_FLAGS, ADDR_MASKS};
		rv = '{8'h0F, 8'h04, 8'h1B, 8'h00, 8'h3F, 8'h3F};
		lo = '{8'h06, 8'h00, 8'h14};
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		chk(init_done, 1'b0);
		n = 0;
		do begin
			apb(1'b0, APB_STATUS, 32'h0);
			n++;
		end while (t[2] !== 1'b1 && n < 100);
		chk(init_done, 1'b1);
		apb(1'b0, APB_IRQ_STAT, 32'h0);
		chk(t[1], 1'b1);
		chk(irq, 1'b0);
		apb(1'b1, APB_IRQ_EN, 32'h1);
		apb(1'b1, APB_IRQ_CLR, 32'h3);
		chk(irq, 1'b0);
		dev(1'b0, ADDR_STARTUP, 8'h00);
		chk(r, 8'h01);
		for (i = 0; i < 6; i++) begin
			dev(1'b0, ra[i], 8'h00);
			chk(r, rv[i]);
		end
		// low codes, then a reserved code that must be refused
		for (i = 0; i < 3; i++) begin
			dev(1'b1, ra[i], lo[i]);
			dev(1'b1, ra[i], lo[i] + 8'h01);
			dev(1'b0, ra[i], 8'h00);
			chk(r, lo[i]);
		end
		chk({prof_b, prof_c, prof_d}, 24'h060014);
		for (i = 0; i < 3; i++)
			dev(1'b1, ra[i], rv[i]);
		chk({prof_b, prof_c, prof_d}, 24'h0F041B);
		dev(1'b1, ADDR_MASKS, 8'h00);
		dev(1'b0, ADDR_ALARM, 8'h00);
		chk(r, 8'h01);
		chk(ipa_if_i.status_pin, 1'b1);
		dev(1'b1, ADDR_FLAGS, 8'h3F);
		dev(1'b0, ADDR_FLAGS, 8'h00);
		chk(r, 8'h00);
		chk(ipa_if_i.status_pin, 1'b0);
		pin_sel <= 1'b0;
		cal_st <= 1'b1;
		@(posedge clk);
		chk(ipa_if_i.status_pin, 1'b1);
		pin_sel <= 1'b1;
		alm_ev <= 6'h04;
		@(posedge clk);
		alm_ev <= 6'h00;
		@(posedge clk);
		chk(ipa_if_i.status_pin, 1'b1);
		dev(1'b0, ADDR_FLAGS, 8'h00);
		chk(r, 8'h04);
		dev(1'b1, ADDR_MASKS, 8'h04);
		dev(1'b0, ADDR_ALARM, 8'h00);
		chk(r, 8'h00);
		chk(ipa_if_i.status_pin, 1'b0);
		dev(1'b1, ADDR_MASKS, 8'h00);
		dev(1'b1, ADDR_FLAGS, 8'h01);
		dev(1'b0, ADDR_ALARM, 8'h00);
		chk(r, 8'h01);
		dev(1'b1, ADDR_FLAGS, 8'h04);
		dev(1'b1, ADDR_ALARM, 8'hFF);
		dev(1'b0, ADDR_ALARM, 8'h00);
		chk(r, 8'h00);
		// host walk to low profile, caller has link and cal disabled
		apb(1'b1, APB_CMD, 32'h0006_0001);
		n = 0;
		do begin
			apb(1'b0, APB_STATUS, 32'h0);
			n++;
		end while (t[3] !== 1'b1 && n < 100);
		chk(t[3], 1'b1);
		chk({prof_b, prof_c, prof_d}, 24'h060014);
		// soft reset, the one access allowed before init is seen again
		apb(1'b1, APB_CMD, 32'h000A_0000);
		n = 0;
		do begin
			apb(1'b0, APB_STATUS, 32'h0);
			n++;
		end while (t[2] !== 1'b1 && n < 100);
		chk(t[2], 1'b1);
		chk({prof_b, prof_c, prof_d}, 24'h0F041B);
		apb(1'b1, APB_IRQ_CLR, 32'h3);
		dev(1'b0, ADDR_FLAGS, 8'h00);
		chk(r, 8'h3F);
		dev(1'b0, ADDR_MASKS, 8'h00);
		chk(r, 8'h3F);
		close_out;
	end
endmodule
